// [pcie_host_request_tracker.sv]
// request tagging, completion routing, timeouts, reordering, link errors
// assumes all inputs come from logic on sys_clk
// Overview of operation
// - one function; latch device number on config writes
// - outgoing request carries client tag
// - completions steered to client by tag
// - receive tags 00, 01, 02; second queue own
// - transmit descriptor tags 04, 05, 06, 07
// - four payload stream tags 08 to 0b
// - management tags 10 read, 11 write
// - interrupt 1e, message 1f; reserved never issued
// - timer starts when request is transmitted
// - timeout between 10 ms and 50 ms
// - split read done after last completion
// - partial data dropped on timeout
// - timeout reports nonfatal and reissues request
// - stream data delivered in request order
// - baseline and advanced error status kept
// - serr enable and parity bits gate reports
// - receiver error correctable; tlp nak, dllp drop
// - bad tlp correctable, nak, drop data
// - bad dllp discarded, counted correctable
// - replay timeout and rollover correctable
// - unexpected completion discarded, nonfatal, header logged
`timescale 1ns/1ps
`default_nettype none
module pcie_host_request_tracker
   import pcie_tag_pkg::*;
#(
   parameter int TICK_CYCLES = TICK_CYCLES_DFLT
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   input wire logic cfg_wr0_valid,
   input wire logic [DEV_W-1:0] cfg_dev_num,
   output logic [DEV_W-1:0] dev_num_q,
   input wire logic req_valid,
   input wire logic [TAG_W-1:0] req_tag,
   input wire logic [CNT_W-1:0] req_ncpl,
   input wire logic [ADDR_W-1:0] req_addr,
   output logic req_done_q,
   output logic req_refused_q,
   output logic tx_valid_q,
   output logic [TAG_W-1:0] tx_tag_q,
   output logic [CNT_W-1:0] tx_ncpl_q,
   output logic [ADDR_W-1:0] tx_addr_q,
   output logic tx_retry_q,
   input wire logic tx_ack,
   input wire logic cpl_valid,
   input wire logic [TAG_W-1:0] cpl_tag,
   input wire logic [DEV_W-1:0] cpl_req_dev,
   input wire logic [DATA_W-1:0] cpl_data,
   input wire logic cpl_poison,
   output logic cli_valid_q,
   output logic [TAG_W-1:0] cli_tag_q,
   output logic [DATA_W-1:0] cli_data_q,
   output logic cli_last_q,
   output logic str_valid_q,
   output logic [TAG_W-1:0] str_tag_q,
   output logic [DATA_W-1:0] str_data_q,
   output logic str_last_q,
   input wire logic phy_rx_err,
   input wire logic rx_pkt_is_tlp,
   input wire logic dll_bad_tlp,
   input wire logic dll_bad_dllp,
   input wire logic replay_timeout,
   input wire logic replay_rollover,
   output logic tlp_nak_q,
   output logic tlp_drop_q,
   output logic dllp_drop_q,
   input wire logic cmd_serr_en,
   input wire logic cmd_parity_resp,
   input wire logic cor_report_en,
   input wire logic nonfatal_report_en,
   input wire logic stat_clear,
   output logic msg_corr_q,
   output logic msg_nonfatal_q,
   output logic hdr_log_valid_q,
   output logic [TAG_W-1:0] hdr_log_tag_q,
   output logic [COR_W-1:0] cor_status_q,
   output logic [UNC_W-1:0] unc_status_q,
   output logic dev_stat_cor_q,
   output logic dev_stat_nonfatal_q,
   output logic parity_det_q,
   output logic master_parity_q,
   output logic [NTAG-1:0] busy_q
);
   logic tick;
   logic [NTAG-1:0] busy_d, sent_q, sent_d, retry_q, retry_d;
   logic [CNT_W-1:0] exp_q [NTAG];
   logic [CNT_W-1:0] exp_d [NTAG];
   logic [CNT_W-1:0] got_q [NTAG];
   logic [CNT_W-1:0] got_d [NTAG];
   logic [4:0] ms_q [NTAG];
   logic [4:0] ms_d [NTAG];
   logic [ADDR_W-1:0] addr_q [NTAG];
   logic [ADDR_W-1:0] addr_d [NTAG];
   logic [DATA_W-1:0] buf_q [NSTREAM][NSTREAM];
   logic [DATA_W-1:0] buf_d [NSTREAM][NSTREAM];
   logic [CNT_W-1:0] dlv_q [NSTREAM];
   logic [CNT_W-1:0] dlv_d [NSTREAM];
   logic [SW-1:0] ord_q [NSTREAM];
   logic [SW-1:0] ord_d [NSTREAM];
   logic [SW-1:0] head_q, head_d, tail_q, tail_d;
   logic [CNT_W-1:0] ocnt_q, ocnt_d;
   logic [DEV_W-1:0] dev_num_d;
   logic req_done_d, req_refused_d, tx_valid_d, tx_retry_d;
   logic [TAG_W-1:0] tx_tag_d, cli_tag_d, str_tag_d, hdr_log_tag_d;
   logic [CNT_W-1:0] tx_ncpl_d;
   logic [ADDR_W-1:0] tx_addr_d;
   logic cli_valid_d, cli_last_d, str_valid_d, str_last_d;
   logic [DATA_W-1:0] cli_data_d, str_data_d;
   logic tlp_nak_d, tlp_drop_d, dllp_drop_d, msg_corr_d, msg_nonfatal_d;
   logic hdr_log_valid_d, dev_stat_cor_d, dev_stat_nonfatal_d;
   logic parity_det_d, master_parity_d;
   logic [COR_W-1:0] cor_status_d, cor_set;
   logic [UNC_W-1:0] unc_status_d, unc_set;
   logic tx_free, rany, req_ok, cpl_ok, push, pop, cto_any;
   logic [TAG_W-1:0] rsel, st;
   logic [SW-1:0] s;

   cto_tick #(.TICK_CYCLES(TICK_CYCLES)) u_tick (
      .sys_clk(sys_clk),
      .arst_n(arst_n),
      .tick_q(tick)
   );

   always_comb begin
      busy_d = busy_q;
      sent_d = sent_q;
      retry_d = retry_q;
      exp_d = exp_q;
      got_d = got_q;
      ms_d = ms_q;
      addr_d = addr_q;
      buf_d = buf_q;
      dlv_d = dlv_q;
      ord_d = ord_q;
      head_d = head_q;
      tail_d = tail_q;
      tx_valid_d = tx_valid_q;
      tx_tag_d = tx_tag_q;
      tx_ncpl_d = tx_ncpl_q;
      tx_addr_d = tx_addr_q;
      tx_retry_d = tx_retry_q;
      cli_valid_d = 1'b0;
      cli_tag_d = cli_tag_q;
      cli_data_d = cli_data_q;
      cli_last_d = 1'b0;
      str_valid_d = 1'b0;
      str_tag_d = str_tag_q;
      str_data_d = str_data_q;
      str_last_d = 1'b0;
      hdr_log_valid_d = 1'b0;
      hdr_log_tag_d = hdr_log_tag_q;
      unc_set = '0;
      push = 1'b0;
      pop = 1'b0;
      cto_any = 1'b0;
      rany = 1'b0;
      rsel = '0;
      parity_det_d = parity_det_q;
      master_parity_d = master_parity_q;
      // device number follows every type 0 config write
      dev_num_d = cfg_wr0_valid ? cfg_dev_num : dev_num_q;
      // request leaves the slot: arm timer or free a posted tag
      tx_free = !tx_valid_q || tx_ack;
      if (tx_valid_q && tx_ack) begin
         tx_valid_d = 1'b0;
         if (tx_ncpl_q != '0) begin
            sent_d[tx_tag_q] = 1'b1;
            ms_d[tx_tag_q] = '0;
            got_d[tx_tag_q] = '0;
         end else begin
            busy_d[tx_tag_q] = 1'b0;
         end
      end
      for (int t = NTAG - 1; t >= 0; t--) begin
         if (retry_q[t]) begin
            rany = 1'b1;
            rsel = TAG_W'(t);
         end
      end
      // reissue of a timed-out read goes ahead of new requests
      if (tx_free && rany) begin
         tx_valid_d = 1'b1;
         tx_tag_d = rsel;
         tx_ncpl_d = exp_q[rsel];
         tx_addr_d = addr_q[rsel];
         tx_retry_d = 1'b1;
         retry_d[rsel] = 1'b0;
      end
      // client tags are the fixed codes; reserved or busy codes refused
      req_ok = req_valid && tx_free && !rany && tag_assigned(req_tag)
         && !busy_q[req_tag]
         && (!tag_is_stream(req_tag)
         || (req_ncpl != '0 && req_ncpl <= BEATS));
      if (req_ok) begin
         tx_valid_d = 1'b1;
         tx_tag_d = req_tag;
         tx_ncpl_d = req_ncpl;
         tx_addr_d = req_addr;
         tx_retry_d = 1'b0;
         busy_d[req_tag] = 1'b1;
         exp_d[req_tag] = req_ncpl;
         addr_d[req_tag] = req_addr;
         if (tag_is_stream(req_tag)) begin
            push = 1'b1;
            ord_d[tail_q] = req_tag[SW-1:0];
            tail_d = tail_q + 2'h1;
         end
      end
      req_done_d = req_ok;
      req_refused_d = req_valid && !req_ok;
      // completion routing
      cpl_ok = tag_assigned(cpl_tag) && sent_q[cpl_tag]
         && got_q[cpl_tag] < exp_q[cpl_tag] && cpl_req_dev == dev_num_q;
      if (cpl_valid && cpl_poison) begin
         parity_det_d = 1'b1;
         master_parity_d = master_parity_q || cmd_parity_resp;
      end
      if (cpl_valid && cpl_ok) begin
         got_d[cpl_tag] = got_q[cpl_tag] + 3'h1;
         if (tag_is_stream(cpl_tag)) begin
            buf_d[cpl_tag[SW-1:0]][got_q[cpl_tag][SW-1:0]] = cpl_data;
         end else begin
            cli_valid_d = 1'b1;
            cli_tag_d = cpl_tag;
            cli_data_d = cpl_data;
            cli_last_d = got_q[cpl_tag] + 3'h1 == exp_q[cpl_tag];
            if (cli_last_d) begin
               busy_d[cpl_tag] = 1'b0;
               sent_d[cpl_tag] = 1'b0;
            end
         end
      end else if (cpl_valid) begin
         unc_set[UNC_UNEXP] = 1'b1;
         hdr_log_valid_d = 1'b1;
         hdr_log_tag_d = cpl_tag;
      end
      // timers run only while completions are still owed
      for (int t = 0; t < NTAG; t++) begin
         if (tick && sent_q[t] && got_q[t] < exp_q[t]) begin
            ms_d[t] = ms_q[t] + 5'h01;
         end
         if (sent_q[t] && sent_d[t] && got_d[t] < exp_q[t]
            && ms_q[t] == CTO_FIRE_TICKS) begin
            cto_any = 1'b1;
            retry_d[t] = 1'b1;
            sent_d[t] = 1'b0;
            got_d[t] = '0;
            ms_d[t] = '0;
         end
      end
      if (cto_any) begin
         unc_set[UNC_CPL_TO] = 1'b1;
      end
      // head stream drains once all its beats are in
      s = ord_q[head_q];
      st = {TAG_TX_DATA0[TAG_W-1:SW], s};
      if (ocnt_q != '0 && sent_q[st] && got_q[st] == exp_q[st]) begin
         str_valid_d = 1'b1;
         str_tag_d = st;
         str_data_d = buf_q[s][dlv_q[s][SW-1:0]];
         str_last_d = dlv_q[s] + 3'h1 == exp_q[st];
         if (str_last_d) begin
            dlv_d[s] = '0;
            pop = 1'b1;
            head_d = head_q + 2'h1;
            busy_d[st] = 1'b0;
            sent_d[st] = 1'b0;
         end else begin
            dlv_d[s] = dlv_q[s] + 3'h1;
         end
      end
      ocnt_d = ocnt_q + {2'b00, push} - {2'b00, pop};
   end

   always_comb begin
      tlp_nak_d = 1'b0;
      tlp_drop_d = 1'b0;
      dllp_drop_d = 1'b0;
      cor_set[COR_REPLAY_TO] = replay_timeout;
      cor_set[COR_REPLAY_ROLL] = replay_rollover;
      cor_set[COR_RX_ERR] = 1'b0;
      cor_set[COR_BAD_TLP] = 1'b0;
      cor_set[COR_BAD_DLLP] = 1'b0;
      // a packet hit at the phy is not flagged again by the link layer
      if (phy_rx_err) begin
         cor_set[COR_RX_ERR] = 1'b1;
         tlp_nak_d = rx_pkt_is_tlp;
         tlp_drop_d = rx_pkt_is_tlp;
         dllp_drop_d = !rx_pkt_is_tlp;
      end else if (dll_bad_tlp) begin
         cor_set[COR_BAD_TLP] = 1'b1;
         tlp_nak_d = 1'b1;
         tlp_drop_d = 1'b1;
      end else if (dll_bad_dllp) begin
         cor_set[COR_BAD_DLLP] = 1'b1;
         dllp_drop_d = 1'b1;
      end
      // sticky status, a new event beats the clear
      cor_status_d = (cor_status_q & ~{COR_W{stat_clear}}) | cor_set;
      unc_status_d = (unc_status_q & ~{UNC_W{stat_clear}}) | unc_set;
      dev_stat_cor_d = (dev_stat_cor_q && !stat_clear) || |cor_set;
      dev_stat_nonfatal_d = (dev_stat_nonfatal_q && !stat_clear)
         || |unc_set;
      msg_corr_d = |cor_set && cor_report_en;
      msg_nonfatal_d = |unc_set && (nonfatal_report_en || cmd_serr_en);
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         busy_q <= '0;
         sent_q <= '0;
         retry_q <= '0;
         exp_q <= '{default: '0};
         got_q <= '{default: '0};
         ms_q <= '{default: '0};
         addr_q <= '{default: '0};
         buf_q <= '{default: '{default: '0}};
         dlv_q <= '{default: '0};
         ord_q <= '{default: '0};
         head_q <= '0;
         tail_q <= '0;
         ocnt_q <= '0;
         dev_num_q <= '0;
         req_done_q <= 1'b0;
         req_refused_q <= 1'b0;
         tx_valid_q <= 1'b0;
         tx_tag_q <= '0;
         tx_ncpl_q <= '0;
         tx_addr_q <= '0;
         tx_retry_q <= 1'b0;
         cli_valid_q <= 1'b0;
         cli_tag_q <= '0;
         cli_data_q <= '0;
         cli_last_q <= 1'b0;
         str_valid_q <= 1'b0;
         str_tag_q <= '0;
         str_data_q <= '0;
         str_last_q <= 1'b0;
         tlp_nak_q <= 1'b0;
         tlp_drop_q <= 1'b0;
         dllp_drop_q <= 1'b0;
         msg_corr_q <= 1'b0;
         msg_nonfatal_q <= 1'b0;
         hdr_log_valid_q <= 1'b0;
         hdr_log_tag_q <= '0;
         cor_status_q <= '0;
         unc_status_q <= '0;
         dev_stat_cor_q <= 1'b0;
         dev_stat_nonfatal_q <= 1'b0;
         parity_det_q <= 1'b0;
         master_parity_q <= 1'b0;
      end else begin
         busy_q <= busy_d;
         sent_q <= sent_d;
         retry_q <= retry_d;
         exp_q <= exp_d;
         got_q <= got_d;
         ms_q <= ms_d;
         addr_q <= addr_d;
         buf_q <= buf_d;
         dlv_q <= dlv_d;
         ord_q <= ord_d;
         head_q <= head_d;
         tail_q <= tail_d;
         ocnt_q <= ocnt_d;
         dev_num_q <= dev_num_d;
         req_done_q <= req_done_d;
         req_refused_q <= req_refused_d;
         tx_valid_q <= tx_valid_d;
         tx_tag_q <= tx_tag_d;
         tx_ncpl_q <= tx_ncpl_d;
         tx_addr_q <= tx_addr_d;
         tx_retry_q <= tx_retry_d;
         cli_valid_q <= cli_valid_d;
         cli_tag_q <= cli_tag_d;
         cli_data_q <= cli_data_d;
         cli_last_q <= cli_last_d;
         str_valid_q <= str_valid_d;
         str_tag_q <= str_tag_d;
         str_data_q <= str_data_d;
         str_last_q <= str_last_d;
         tlp_nak_q <= tlp_nak_d;
         tlp_drop_q <= tlp_drop_d;
         dllp_drop_q <= dllp_drop_d;
         msg_corr_q <= msg_corr_d;
         msg_nonfatal_q <= msg_nonfatal_d;
         hdr_log_valid_q <= hdr_log_valid_d;
         hdr_log_tag_q <= hdr_log_tag_d;
         cor_status_q <= cor_status_d;
         unc_status_q <= unc_status_d;
         dev_stat_cor_q <= dev_stat_cor_d;
         dev_stat_nonfatal_q <= dev_stat_nonfatal_d;
         parity_det_q <= parity_det_d;
         master_parity_q <= master_parity_d;
      end
   end

   a_dev_latch: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cfg_wr0_valid |=> dev_num_q == $past(cfg_dev_num))
      else $error("device number not latched");
   a_tag_legal: assert property (@(posedge sys_clk) disable iff (!arst_n)
      tx_valid_q |-> tag_assigned(tx_tag_q))
      else $error("reserved tag issued");
   a_tx_hold: assert property (@(posedge sys_clk) disable iff (!arst_n)
      tx_valid_q && !tx_ack |=> tx_valid_q && $stable(tx_tag_q))
      else $error("request dropped before transmit");
   a_tag_reuse: assert property (@(posedge sys_clk) disable iff (!arst_n)
      req_valid && busy_q[req_tag] |=> req_refused_q && !req_done_q)
      else $error("busy tag accepted");
   a_rx_err: assert property (@(posedge sys_clk) disable iff (!arst_n)
      phy_rx_err |=> cor_status_q[COR_RX_ERR]
         && (tlp_nak_q == $past(rx_pkt_is_tlp))
         && (dllp_drop_q != $past(rx_pkt_is_tlp)))
      else $error("receiver error handling wrong");
   a_bad_tlp: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !phy_rx_err && dll_bad_tlp |=> tlp_nak_q && tlp_drop_q
         && cor_status_q[COR_BAD_TLP])
      else $error("bad tlp not naked");
   a_bad_dllp: assert property (@(posedge sys_clk) disable iff (!arst_n)
      !phy_rx_err && !dll_bad_tlp && dll_bad_dllp |=> dllp_drop_q
         && !tlp_nak_q && cor_status_q[COR_BAD_DLLP])
      else $error("bad dllp not dropped");
   a_replay_cor: assert property (@(posedge sys_clk) disable iff (!arst_n)
      replay_timeout || replay_rollover |=> dev_stat_cor_q
         && (msg_corr_q == $past(cor_report_en)))
      else $error("replay event not correctable");
   a_unexp_cpl: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cpl_valid && !sent_q[cpl_tag] |=> unc_status_q[UNC_UNEXP]
         && hdr_log_valid_q && !cli_valid_q)
      else $error("unexpected completion not discarded");
   a_cto_retry: assert property (@(posedge sys_clk) disable iff (!arst_n)
      cto_any |=> unc_status_q[UNC_CPL_TO] && (|retry_q || tx_retry_q))
      else $error("timeout without reissue");
   a_serr_gate: assert property (@(posedge sys_clk) disable iff (!arst_n)
      msg_nonfatal_q |-> $past(nonfatal_report_en || cmd_serr_en))
      else $error("nonfatal message not gated");
endmodule
`default_nettype wire

// [pcie_tag_pkg.sv]
// tag codes, widths, timing constants and tag decoding for the tracker
// assumes a single 25 MHz core clock shared with the transaction layer
package pcie_tag_pkg;
   localparam int TAG_W = 5;
   localparam int NTAG = 32;
   localparam int CNT_W = 3;
   localparam int DATA_W = 32;
   localparam int ADDR_W = 32;
   localparam int DEV_W = 5;
   localparam int NSTREAM = 4;
   localparam int SW = 2;
   localparam logic [CNT_W-1:0] BEATS = 3'h4;

   localparam logic [TAG_W-1:0] TAG_RX_DATA_WR = 5'h00;
   localparam logic [TAG_W-1:0] TAG_RX_DESC_RD = 5'h01;
   localparam logic [TAG_W-1:0] TAG_RX_DESC_WB = 5'h02;
   localparam logic [TAG_W-1:0] TAG_TX_DESC_RD0 = 5'h04;
   localparam logic [TAG_W-1:0] TAG_TX_DESC_WB0 = 5'h05;
   localparam logic [TAG_W-1:0] TAG_TX_DESC_RD1 = 5'h06;
   localparam logic [TAG_W-1:0] TAG_TX_DESC_WB1 = 5'h07;
   localparam logic [TAG_W-1:0] TAG_TX_DATA0 = 5'h08;
   localparam logic [TAG_W-1:0] TAG_TX_DATA1 = 5'h09;
   localparam logic [TAG_W-1:0] TAG_TX_DATA2 = 5'h0a;
   localparam logic [TAG_W-1:0] TAG_TX_DATA3 = 5'h0b;
   localparam logic [TAG_W-1:0] TAG_RX2_DESC_RD = 5'h0c;
   localparam logic [TAG_W-1:0] TAG_RX2_DESC_WB = 5'h0e;
   localparam logic [TAG_W-1:0] TAG_MGMT_RD = 5'h10;
   localparam logic [TAG_W-1:0] TAG_MGMT_WR = 5'h11;
   localparam logic [TAG_W-1:0] TAG_MSI = 5'h1e;
   localparam logic [TAG_W-1:0] TAG_MSG = 5'h1f;

   localparam int CLK_HZ = 25_000_000;
   localparam int TICK_US = 1000;
   localparam int TICK_CYCLES_DFLT = CLK_HZ / 1_000_000 * TICK_US;
   localparam int CTO_MIN_MS = 10;
   localparam int CTO_MAX_MS = 50;
   localparam logic [4:0] CTO_FIRE_TICKS = 5'((CTO_MIN_MS + CTO_MAX_MS) / 2);

   localparam int COR_W = 5;
   localparam int COR_RX_ERR = 0;
   localparam int COR_BAD_TLP = 1;
   localparam int COR_BAD_DLLP = 2;
   localparam int COR_REPLAY_TO = 3;
   localparam int COR_REPLAY_ROLL = 4;
   localparam int UNC_W = 2;
   localparam int UNC_CPL_TO = 0;
   localparam int UNC_UNEXP = 1;

   function automatic logic tag_assigned(input logic [TAG_W-1:0] t);
      case (t)
         TAG_RX_DATA_WR, TAG_RX_DESC_RD, TAG_RX_DESC_WB,
         TAG_TX_DESC_RD0, TAG_TX_DESC_WB0, TAG_TX_DESC_RD1, TAG_TX_DESC_WB1,
         TAG_TX_DATA0, TAG_TX_DATA1, TAG_TX_DATA2, TAG_TX_DATA3,
         TAG_RX2_DESC_RD, TAG_RX2_DESC_WB, TAG_MGMT_RD, TAG_MGMT_WR,
         TAG_MSI, TAG_MSG: return 1'b1;
         default: return 1'b0;
      endcase
   endfunction

   function automatic logic tag_is_stream(input logic [TAG_W-1:0] t);
      return t[TAG_W-1:SW] == TAG_TX_DATA0[TAG_W-1:SW];
   endfunction
endpackage

// [cto_tick.sv]
// millisecond tick for the completion timers
// assumes the core clock and reset of the tracker
`timescale 1ns/1ps
`default_nettype none
module cto_tick #(
   parameter int TICK_CYCLES = 25000
) (
   input wire logic sys_clk,
   input wire logic arst_n,
   output logic tick_q
);
   logic [15:0] cnt_q;
   logic [15:0] cnt_d;
   logic tick_d;

   always_comb begin
      tick_d = cnt_q == 16'(TICK_CYCLES - 1);
      cnt_d = tick_d ? 16'h0000 : cnt_q + 16'h0001;
   end

   always_ff @(posedge sys_clk or negedge arst_n) begin
      if (!arst_n) begin
         cnt_q <= 16'h0000;
         tick_q <= 1'b0;
      end else begin
         cnt_q <= cnt_d;
         tick_q <= tick_d;
      end
   end
endmodule
`default_nettype wire

// [rc_model.sv]
// partner model of the transaction layer and upstream completer
// assumes the tracker's sys_clk; drives its outputs on the falling edge
`timescale 1ns/1ps
`default_nettype none
module rc_model
   import pcie_tag_pkg::*;
(
   input wire logic sys_clk,
   input wire logic tx_valid_q,
   input wire logic [3:0] slow,
   output logic tx_ack,
   output logic cpl_valid,
   output logic [TAG_W-1:0] cpl_tag,
   output logic [DEV_W-1:0] cpl_req_dev,
   output logic [DATA_W-1:0] cpl_data
);
   logic [3:0] wait_n = 4'h0;
   initial begin
      tx_ack = 1'b0;
      cpl_valid = 1'b0;
      cpl_tag = 5'h00;
      cpl_req_dev = 5'h00;
      cpl_data = 32'h0;
   end
   // take the offered request after slow cycles
   always @(negedge sys_clk) begin
      if (tx_valid_q && !tx_ack && wait_n >= slow) begin
         tx_ack <= 1'b1;
         wait_n <= 4'h0;
      end else begin
         tx_ack <= 1'b0;
         if (tx_valid_q && !tx_ack) wait_n <= wait_n + 4'h1;
      end
   end
   // one completion word; idle lines flip away from the last value
   task automatic send_cpl(input logic [TAG_W-1:0] t,
      input logic [DATA_W-1:0] d, input logic [DEV_W-1:0] dv);
      @(negedge sys_clk);
      cpl_valid = 1'b1;
      cpl_tag = t;
      cpl_data = d;
      cpl_req_dev = dv;
      @(negedge sys_clk);
      cpl_valid = 1'b0;
      cpl_tag = ~t;
      cpl_data = ~d;
      cpl_req_dev = ~dv;
   endtask
endmodule
`default_nettype wire

// [pcie_host_request_tracker_tb_top.sv]
// self-checking bench for the request tracker
// assumes the tag package, tracker and rc_model are compiled first
`timescale 1ns/1ps
`default_nettype none
module pcie_host_request_tracker_tb_top;
   import pcie_tag_pkg::*;
   localparam logic [4:0] DEV = 5'h05;
   logic sys_clk = 1'b0;
   logic arst_n = 1'b0;
   logic cfg_wr0_valid = 1'b0;
   logic [4:0] cfg_dev_num = 5'h00;
   logic req_valid = 1'b0;
   logic [4:0] req_tag = 5'h00;
   logic [2:0] req_ncpl = 3'h0;
   logic [5:0] lerr = 6'h00;
   logic rpt_en = 1'b1;
   logic serr = 1'b0;
   logic clr = 1'b0;
   logic poison = 1'b0;
   logic [3:0] slow = 4'h0;
   logic tx_ack, cpl_valid, req_done_q, req_refused_q, tx_valid_q;
   logic tx_retry_q, cli_valid_q, cli_last_q, str_valid_q, tlp_nak_q;
   logic tlp_drop_q, dllp_drop_q, msg_corr_q, msg_nonfatal_q;
   logic hdr_log_valid_q, str_last_q, dsc, dsn, par_d, par_m;
   logic [2:0] tx_ncpl_q;
   logic [4:0] cpl_tag, cpl_req_dev, dev_num_q, tx_tag_q, cli_tag_q;
   logic [4:0] str_tag_q, hdr_log_tag_q, cor_status_q;
   logic [31:0] cpl_data, cli_data_q, str_data_q, busy_q, tx_addr_q;
   logic [1:0] unc_status_q;
   int failures = 0;
   int n_checks = 0;
   int cyc = 0;

   pcie_host_request_tracker #(.TICK_CYCLES(10))
      pcie_host_request_tracker_inst (
      .sys_clk, .arst_n, .cfg_wr0_valid, .cfg_dev_num, .dev_num_q,
      .req_valid, .req_tag, .req_ncpl, .req_addr({27'h0, req_tag}),
      .req_done_q, .req_refused_q, .tx_valid_q, .tx_tag_q,
      .tx_ncpl_q, .tx_addr_q, .tx_retry_q, .tx_ack, .cpl_valid,
      .cpl_tag, .cpl_req_dev, .cpl_data, .cpl_poison(poison),
      .cli_valid_q, .cli_tag_q, .cli_data_q, .cli_last_q, .str_valid_q,
      .str_tag_q, .str_data_q, .str_last_q, .phy_rx_err(lerr[0]),
      .rx_pkt_is_tlp(lerr[1]), .dll_bad_tlp(lerr[2]),
      .dll_bad_dllp(lerr[3]), .replay_timeout(lerr[4]),
      .replay_rollover(lerr[5]), .tlp_nak_q, .tlp_drop_q, .dllp_drop_q,
      .cmd_serr_en(serr), .cmd_parity_resp(rpt_en), .cor_report_en(rpt_en),
      .nonfatal_report_en(rpt_en), .stat_clear(clr), .msg_corr_q,
      .msg_nonfatal_q, .hdr_log_valid_q, .hdr_log_tag_q, .cor_status_q,
      .unc_status_q, .dev_stat_cor_q(dsc), .dev_stat_nonfatal_q(dsn),
      .parity_det_q(par_d), .master_parity_q(par_m), .busy_q);

   rc_model rc_model_inst (.sys_clk, .tx_valid_q, .slow, .tx_ack,
      .cpl_valid, .cpl_tag, .cpl_req_dev, .cpl_data);

   initial begin
      forever #20 sys_clk = ~sys_clk;
   end

   task automatic end_sim;
      if (failures == 0 && n_checks > 0) $display("SIMULATION PASSED");
      else $display("SIMULATION FAILED");
      $finish;
   endtask

   always @(posedge sys_clk) begin
      cyc++;
      if (cyc == 3000) begin
         failures++;
         end_sim();
      end
   end

   task automatic chk(input logic [39:0] g, e, input string m);
      n_checks++;
      if (g !== e) begin
         failures++;
         $display("[ERR] %0t %s", $time, m);
      end
   endtask

   task automatic req(input logic [4:0] t, input logic [2:0] n,
      input logic ok);
      @(negedge sys_clk);
      req_valid = 1'b1;
      req_tag = t;
      req_ncpl = n;
      @(negedge sys_clk);
      req_valid = 1'b0;
      chk({req_done_q, req_refused_q}, {ok, !ok}, "req answer");
      if (ok) chk({tx_tag_q, tx_ncpl_q, tx_addr_q},
         {t, n, 27'h0, t}, "tx request");
   endtask

   task automatic cpl(input logic [4:0] t, input logic [31:0] d);
      rc_model_inst.send_cpl(t, d, DEV);
   endtask

   task automatic wait_tx;
      for (int k = 0; k < 20 && tx_valid_q; k++) @(negedge sys_clk);
   endtask

   task automatic s_cfg(input logic [4:0] d);
      @(negedge sys_clk);
      cfg_wr0_valid = 1'b1;
      cfg_dev_num = d;
      @(negedge sys_clk);
      cfg_wr0_valid = 1'b0;
      chk(dev_num_q, d, "dev number");
   endtask

   task automatic s_tags;
      logic [31:0] m = 32'hc003_50f7;
      for (int i = 0; i < 32; i++) req(i[4:0], 3'h0, m[i]);
      req(5'h08, 3'h5, 1'b0);
   endtask

   task automatic s_split;
      req(5'h01, 3'h2, 1'b1);
      req(5'h01, 3'h2, 1'b0);
      chk(busy_q[1], 1'b1, "busy");
      cpl(5'h01, 32'ha5a5_0001);
      chk({cli_valid_q, cli_last_q, cli_tag_q}, 7'h41, "cpl 1");
      chk(cli_data_q, 32'ha5a5_0001, "cpl data");
      poison = 1'b1;
      cpl(5'h01, 32'h5a5a_0002);
      poison = 1'b0;
      chk({cli_valid_q, cli_last_q, busy_q[1]}, 3'b110, "cpl 2");
      chk({par_d, par_m}, 2'b11, "parity log");
   endtask

   task automatic s_unexp;
      cpl(5'h04, 32'h1234_5678);
      chk({cli_valid_q, unc_status_q[1], hdr_log_valid_q,
         msg_nonfatal_q}, 4'h7, "unexpected");
      chk(hdr_log_tag_q, 5'h04, "header tag");
      rpt_en = 1'b0;
      cpl(5'h04, 32'h0000_0000);
      chk(msg_nonfatal_q, 1'b0, "nonfatal gated");
      serr = 1'b1;
      cpl(5'h04, 32'h0000_0000);
      chk(msg_nonfatal_q, 1'b1, "serr message");
      rpt_en = 1'b1;
      serr = 1'b0;
   endtask

   task automatic s_stream;
      logic [37:0] got[$];
      req(5'h08, 3'h2, 1'b1);
      req(5'h09, 3'h1, 1'b1);
      cpl(5'h09, 32'h0903);
      cpl(5'h08, 32'h0801);
      cpl(5'h08, 32'h0802);
      repeat (20) begin
         if (str_valid_q) got.push_back({str_last_q, str_tag_q, str_data_q});
         @(negedge sys_clk);
      end
      chk(got.size(), 3, "beat count");
      chk(got[0], {1'b0, 5'h08, 32'h0801}, "beat 0");
      chk(got[1], {1'b1, 5'h08, 32'h0802}, "beat 1");
      chk(got[2], {1'b1, 5'h09, 32'h0903}, "beat 2");
   endtask

   task automatic lev(input logic [5:0] ev, input logic [2:0] e,
      input int b);
      @(negedge sys_clk);
      lerr = ev;
      @(negedge sys_clk);
      lerr = 6'h00;
      chk({tlp_nak_q, tlp_drop_q, dllp_drop_q}, e, "link action");
      chk(cor_status_q[b], 1'b1, "cor status");
      if (b != 2) chk(msg_corr_q, rpt_en, "cor message");
   endtask

   task automatic s_link;
      lev(6'h03, 3'b110, 0);
      lev(6'h01, 3'b001, 0);
      lev(6'h04, 3'b110, 1);
      lev(6'h08, 3'b001, 2);
      lev(6'h10, 3'b000, 3);
      rpt_en = 1'b0;
      lev(6'h20, 3'b000, 4);
      rpt_en = 1'b1;
      chk({dsc, dsn, cor_status_q, unc_status_q}, 9'h1fe, "status");
      @(negedge sys_clk);
      clr = 1'b1;
      @(negedge sys_clk);
      clr = 1'b0;
      chk({dsc, dsn, cor_status_q, unc_status_q}, 9'h000, "clear");
   endtask

   task automatic s_timeout;
      int n = 0;
      slow = 4'h5;
      req(5'h10, 3'h2, 1'b1);
      wait_tx();
      cpl(5'h10, 32'h1001);
      while (unc_status_q[0] !== 1'b1 && n < 600) begin
         @(negedge sys_clk);
         n++;
      end
      chk(n >= 97 && n <= 500, 1'b1, "timeout window");
      chk(msg_nonfatal_q, 1'b1, "timeout message");
      for (int k = 0; k < 20 && !tx_valid_q; k++) @(negedge sys_clk);
      chk({tx_valid_q, tx_retry_q, tx_tag_q}, 7'h70, "reissue");
      wait_tx();
      cpl(5'h10, 32'h1002);
      chk(cli_last_q, 1'b0, "partial dropped");
      cpl(5'h10, 32'h1003);
      chk(cli_last_q, 1'b1, "retry done");
   endtask

   initial begin
      repeat (6) @(negedge sys_clk);
      arst_n = 1'b1;
      chk({busy_q, tx_valid_q, cor_status_q, par_d, par_m}, 40'h0, "reset");
      s_cfg(5'h13);
      s_cfg(DEV);
      s_tags();
      s_split();
      s_unexp();
      s_stream();
      s_link();
      s_timeout();
      end_sim();
   end
endmodule
`default_nettype wire
